// ### verilog/ledpwm_pkg.sv
package ledpwm_pkg;
  localparam int unsigned CH_N = 16;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned PCNT_W = 5;

  // Second state-setting word, bit positions (shifted MSB first)
  localparam int unsigned SW2_THERMAL_OFF = 15;
  localparam int unsigned SW2_CLKOPEN_OFF = 14;
  localparam int unsigned SW2_OPEN_EN = 13;
  localparam int unsigned SW2_SHORT_EN = 12;
  localparam int unsigned SW2_ASYNC = 11;
  localparam int unsigned SW2_DIVIDE = 10;
  localparam int unsigned SW2_AUTO_STBY = 9;
  localparam int unsigned SW2_THRESH_HIGH = 8;
  localparam int unsigned SW2_DELAY_OFF = 7;
  localparam int unsigned SW2_SERIAL_DATA_OUT_FALL = 6;
  localparam int unsigned SW2_ONESHOT = 5;
  localparam int unsigned SW2_LOW_ZERO_W = 5;
  localparam logic [WORD_W-1:0] SW2_RESET = 16'h0000;

  // Serial clock pulse counts while the strobe is high
  localparam logic [PCNT_W-1:0] CMD_LATCH_PULSES = 5'h01;
  localparam logic [PCNT_W-1:0] CMD_APPLY_PULSES = 5'h03;
  localparam logic [PCNT_W-1:0] CMD_STOP_PULSES = 5'h05;
  localparam logic [PCNT_W-1:0] CMD_SW2_PULSES_A = 5'h0f;
  localparam logic [PCNT_W-1:0] CMD_SW2_PULSES_B = 5'h10;

  // Resolution select encoding and per-resolution period masks
  localparam logic [1:0] RES_16 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] RES_10 = 2'h3;
  localparam logic [WORD_W-1:0] MASK_16 = 16'hffff;
  localparam logic [WORD_W-1:0] MASK_14 = 16'h3fff;
  localparam logic [WORD_W-1:0] MASK_12 = 16'h0fff;
  localparam logic [WORD_W-1:0] MASK_10 = 16'h03ff;
  localparam int unsigned SEG_BITS = 7;
  localparam logic [3:0] SEG_SHIFT_16 = 4'h9;
  localparam logic [3:0] SEG_SHIFT_14 = 4'h7;
  localparam logic [3:0] SEG_SHIFT_12 = 4'h5;
  localparam logic [3:0] SEG_SHIFT_10 = 4'h3;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WAKE_TIME_NS = 30000;
  localparam int unsigned WAKE_CYC_RAW = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
  localparam int unsigned WAKE_CNT_W = 10;
  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_CYC - 1);

  typedef enum logic {PWM_IDLE, PWM_RUN} ledpwm_run_t;
  typedef enum logic [1:0] {STBY_NORMAL, STBY_SLEEP, STBY_WAKE} ledpwm_stby_t;
endpackage

// ### verilog/ledpwm_sync.sv
`timescale 1ns/1ps
module ledpwm_sync (
  input wire logic clock,
  input wire logic din,
  output logic dout
);
  logic meta_q;

  always_ff @(posedge clock) begin
    meta_q <= din;
    dout <= meta_q;
  end
endmodule

// ### verilog/ledpwm_channel.sv
`timescale 1ns/1ps
module ledpwm_channel #(
  parameter logic [15:0] IDX = 16'h0000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wr_pending,
  input wire logic [15:0] wr_data,
  input wire logic snap,
  input wire logic go_now,
  input wire logic go_staged,
  input wire logic running,
  input wire logic divide,
  input wire logic stagger,
  input wire logic [15:0] cnt,
  input wire logic [15:0] mask,
  input wire logic [3:0] seg_shift,
  output logic drive,
  output logic all_zero
);
  logic [15:0] pending_q;
  logic [15:0] staged_q;
  logic [15:0] active_q;
  logic [15:0] phase;
  logic [15:0] seg;
  logic [15:0] pos;
  logic [15:0] per_seg;
  logic [15:0] on_seg;
  logic on_div;
  logic on_norm;

  localparam int unsigned SEG_BITS_C = 7;

  // Staggered start: each channel lags by its index in grey clocks
  assign phase = (cnt - (stagger ? IDX : 16'h0000)) & mask;
  assign seg = phase >> seg_shift;
  assign pos = phase & (mask >> SEG_BITS_C);
  assign per_seg = active_q >> SEG_BITS_C;
  // Remainder spread as one extra step over the first segments
  assign on_seg = per_seg + {15'h0000, (seg[6:0] < active_q[6:0])};
  assign on_div = pos < on_seg;
  assign on_norm = phase < active_q;
  assign all_zero = (pending_q == 16'h0000) && (active_q == 16'h0000);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pending_q <= 16'h0000;
      staged_q <= 16'h0000;
      active_q <= 16'h0000;
      drive <= 1'b0;
    end else begin
      if (wr_pending) pending_q <= wr_data;
      if (snap) staged_q <= pending_q;
      if (go_now) active_q <= pending_q;
      else if (go_staged) active_q <= staged_q;
      drive <= running && (divide ? on_div : on_norm);
    end
  end
endmodule

// ### verilog/ledpwm_top.sv
`timescale 1ns/1ps
// Contract
// - Open-load detect enable bit: 0 off (reset), 1 on.
// - Shorted-output detect enable bit: 0 off (reset), 1 on.
// - Sync bit: 0 synchronous update (reset), 1 asynchronous update.
// - Output style bit: 0 single pulse (reset), 1 divided output.
// - Auto-standby set: all data zero gives standby, else pre-standby as normal.
// - Standby keeps data and serial input; bit 0 (reset) disables it.
// - Leaving standby takes about 30 us before pre-standby.
// - Auto-standby only acts at 16-bit resolution.
// - Threshold bit: 0 first short threshold (reset), 1 second.
// - Delay bit: 0 staggered turn-on enabled (reset), 1 disabled.
// - Edge bit: 0 serial out on rising edge (reset), 1 falling.
// - Repeat bit 0: periods repeat after apply until stop command.
// - Repeat bit 1: one period per apply command.
// - Normal mode: sixteen words each latched into the data register.
// - Latched data reaches outputs only after an apply command.
// - Speed mode: fifteen latches then apply latches last word and applies.
// - Asynchronous: apply aborts period and restarts at once with new data.
// - Synchronous: apply lets the period finish, then new data.
// - Synchronous: several applies in one period, the last one wins.
// - Divided mode spreads on-time over 128 segments of the period.
// - Fifteen or sixteen pulses with strobe high load the state word.
module ledpwm_top #(
  parameter logic [4:0] LATCH_PULSES = ledpwm_pkg::CMD_LATCH_PULSES,
  parameter logic [4:0] APPLY_PULSES = ledpwm_pkg::CMD_APPLY_PULSES,
  parameter logic [4:0] STOP_PULSES = ledpwm_pkg::CMD_STOP_PULSES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  input wire logic grey_clock,
  input wire logic [1:0] resolution_sel,
  output logic serial_data_out,
  output logic [ledpwm_pkg::CH_N-1:0] channel_output,
  output logic open_load_detect_en,
  output logic short_out_detect_en,
  output logic short_threshold_high_sel,
  output logic output_delay_en,
  output logic standby,
  output logic pwm_running
);
  import ledpwm_pkg::*;

  // Serial clock domain
  logic srst_b;
  logic serial_data_out_fall_s;
  logic [WORD_W-1:0] shreg_q;
  logic [PCNT_W-1:0] pcnt_q;
  logic serial_data_out_fall_q;
  logic [WORD_W-1:0] cfg_q;

  ledpwm_sync u_srst (
    .clock(serial_clock),
    .din(rst_b),
    .dout(srst_b)
  );

  ledpwm_sync u_edge_sync (
    .clock(serial_clock),
    .din(cfg_q[SW2_SERIAL_DATA_OUT_FALL]),
    .dout(serial_data_out_fall_s)
  );

  // Pulses while the strobe is high count the command; others shift data
  always_ff @(posedge serial_clock) begin
    if (!srst_b) begin
      shreg_q <= 16'h0000;
      pcnt_q <= 5'h00;
    end else if (latch_strobe) begin
      if (pcnt_q != 5'h1f) pcnt_q <= pcnt_q + 5'h01;
    end else begin
      shreg_q <= {shreg_q[WORD_W-2:0], serial_data_in};
      pcnt_q <= 5'h00;
    end
  end

  always_ff @(negedge serial_clock) begin
    serial_data_out_fall_q <= shreg_q[WORD_W-1];
  end

  // Both candidates are flops; the select is static in normal use
  assign serial_data_out = serial_data_out_fall_s ? serial_data_out_fall_q : shreg_q[WORD_W-1];

  // System clock domain: pin synchronisers
  logic strobe_s;
  logic strobe_prev_q;
  logic grey_s;
  logic grey_prev_q;

  ledpwm_sync u_strobe_sync (
    .clock(clock),
    .din(latch_strobe),
    .dout(strobe_s)
  );

  ledpwm_sync u_grey_sync (
    .clock(clock),
    .din(grey_clock),
    .dout(grey_s)
  );

  // Resolution pins are static, so a per-bit crossing is safe
  logic [1:0] res_s;

  ledpwm_sync u_res0_sync (
    .clock(clock),
    .din(resolution_sel[0]),
    .dout(res_s[0])
  );

  ledpwm_sync u_res1_sync (
    .clock(clock),
    .din(resolution_sel[1]),
    .dout(res_s[1])
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      strobe_prev_q <= 1'b0;
      grey_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_s;
      grey_prev_q <= grey_s;
    end
  end

  // Command decode. Shift word and pulse count are quiet once the strobe
  // has fallen, since the serial clock stands still until the next frame.
  logic strobe_fall;
  logic grey_rise;
  logic is_latch;
  logic is_apply;
  logic is_stop;
  logic is_cfg;

  assign strobe_fall = strobe_prev_q && !strobe_s;
  assign grey_rise = grey_s && !grey_prev_q;
  assign is_latch = strobe_fall && (pcnt_q == LATCH_PULSES);
  assign is_apply = strobe_fall && (pcnt_q == APPLY_PULSES);
  assign is_stop = strobe_fall && (pcnt_q == STOP_PULSES);
  assign is_cfg = strobe_fall && ((pcnt_q == CMD_SW2_PULSES_A) || (pcnt_q == CMD_SW2_PULSES_B));

  // State word 2
  logic cfg_async;
  logic cfg_divide;
  logic cfg_auto_stby;
  logic cfg_stagger;
  logic cfg_oneshot;

  always_ff @(posedge clock) begin
    if (!rst_b) cfg_q <= SW2_RESET;
    else if (is_cfg) cfg_q <= {shreg_q[WORD_W-1:SW2_LOW_ZERO_W], 5'h00};
  end

  assign cfg_async = cfg_q[SW2_ASYNC];
  assign cfg_divide = cfg_q[SW2_DIVIDE];
  assign cfg_auto_stby = cfg_q[SW2_AUTO_STBY];
  assign cfg_stagger = !cfg_q[SW2_DELAY_OFF];
  assign cfg_oneshot = cfg_q[SW2_ONESHOT];
  assign open_load_detect_en = cfg_q[SW2_OPEN_EN];
  assign short_out_detect_en = cfg_q[SW2_SHORT_EN];
  assign short_threshold_high_sel = cfg_q[SW2_THRESH_HIGH];

  // Registered so the pin comes from a flop, loaded with the word
  always_ff @(posedge clock) begin
    if (!rst_b) output_delay_en <= 1'b1;
    else if (is_cfg) output_delay_en <= !shreg_q[SW2_DELAY_OFF];
  end

  // Channel slot pointer and apply pipeline
  logic [SLOT_W-1:0] slot_q;
  logic apply_go_q;
  logic stop_q;
  logic [WORD_W-1:0] word_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      slot_q <= 4'h0;
      apply_go_q <= 1'b0;
      stop_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      if (is_latch) slot_q <= slot_q + 4'h1;
      else if (is_apply) slot_q <= 4'h0;
      // Apply fires one cycle late so a word latched with it is in place
      apply_go_q <= is_apply;
      stop_q <= is_stop;
      word_q <= shreg_q;
    end
  end

  // Grey counter and run control
  ledpwm_run_t run_q;
  logic [WORD_W-1:0] cnt_q;
  logic [WORD_W-1:0] mask;
  logic [3:0] seg_shift;
  logic staged_valid_q;
  logic running;
  logic period_end;
  logic go_now;
  logic snap;
  logic go_staged;

  assign mask = (res_s == RES_16) ? MASK_16 :
                (res_s == RES_14) ? MASK_14 :
                (res_s == RES_12) ? MASK_12 : MASK_10;
  assign seg_shift = (res_s == RES_16) ? SEG_SHIFT_16 :
                     (res_s == RES_14) ? SEG_SHIFT_14 :
                     (res_s == RES_12) ? SEG_SHIFT_12 : SEG_SHIFT_10;
  assign running = (run_q == PWM_RUN);
  assign period_end = running && grey_rise && (cnt_q == mask);
  assign go_now = apply_go_q && (!running || cfg_async);
  assign snap = apply_go_q && running && !cfg_async;
  assign go_staged = period_end && staged_valid_q && !go_now;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_q <= PWM_IDLE;
      cnt_q <= 16'h0000;
    end else if (stop_q) begin
      run_q <= PWM_IDLE;
      cnt_q <= 16'h0000;
    end else if (go_now) begin
      run_q <= PWM_RUN;
      cnt_q <= 16'h0000;
    end else begin
      case (run_q)
        PWM_IDLE: cnt_q <= 16'h0000;
        PWM_RUN: begin
          if (period_end) begin
            cnt_q <= 16'h0000;
            if (cfg_oneshot && !staged_valid_q && !snap) run_q <= PWM_IDLE;
          end else if (grey_rise) begin
            cnt_q <= (cnt_q + 16'h0001) & mask;
          end
        end
        default: run_q <= PWM_IDLE;
      endcase
    end
  end

  // Pending apply flag: a new apply in the ending cycle keeps it set
  always_ff @(posedge clock) begin
    if (!rst_b) staged_valid_q <= 1'b0;
    else if (snap) staged_valid_q <= 1'b1;
    else if (period_end || go_now || stop_q) staged_valid_q <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) pwm_running <= 1'b0;
    else pwm_running <= running;
  end

  // Channels
  logic [CH_N-1:0] ch_zero;

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ch
      ledpwm_channel #(.IDX(16'(gi))) u_ch (
        .clock(clock),
        .rst_b(rst_b),
        .wr_pending((is_latch || is_apply) && (slot_q == 4'(gi))),
        .wr_data(shreg_q),
        .snap(snap),
        .go_now(go_now),
        .go_staged(go_staged),
        .running(running),
        .divide(cfg_divide),
        .stagger(cfg_stagger),
        .cnt(cnt_q),
        .mask(mask),
        .seg_shift(seg_shift),
        .drive(channel_output[gi]),
        .all_zero(ch_zero[gi])
      );
    end
  endgenerate

  // Auto-standby: only logic stays powered, so data and serial input live on
  ledpwm_stby_t stby_q;
  logic [WAKE_CNT_W-1:0] wake_cnt_q;
  logic sleep_cond;

  assign sleep_cond = cfg_auto_stby && (res_s == RES_16) && (&ch_zero);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stby_q <= STBY_NORMAL;
      wake_cnt_q <= '0;
    end else begin
      case (stby_q)
        STBY_NORMAL: if (sleep_cond) stby_q <= STBY_SLEEP;
        STBY_SLEEP: if (!sleep_cond) begin
          stby_q <= STBY_WAKE;
          wake_cnt_q <= '0;
        end
        STBY_WAKE: begin
          if (sleep_cond) stby_q <= STBY_SLEEP;
          else if (wake_cnt_q == WAKE_LAST) stby_q <= STBY_NORMAL;
          else wake_cnt_q <= wake_cnt_q + 10'h001;
        end
        default: stby_q <= STBY_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) standby <= 1'b0;
    else standby <= (stby_q != STBY_NORMAL);
  end

  // Checks
  a_open_en: assert property (@(posedge clock) disable iff (!rst_b)
    is_cfg |=> open_load_detect_en == $past(shreg_q[SW2_OPEN_EN]))
    else $error("open-load enable not loaded from state word");
  a_short_en: assert property (@(posedge clock) disable iff (!rst_b)
    is_cfg |=> short_out_detect_en == $past(shreg_q[SW2_SHORT_EN]))
    else $error("short enable not loaded from state word");
  a_cfg_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !is_cfg |=> $stable(cfg_q))
    else $error("state word changed without its command");
  a_async_restart: assert property (@(posedge clock) disable iff (!rst_b)
    apply_go_q && cfg_async && !stop_q |=> running && cnt_q == 16'h0000)
    else $error("async apply did not restart period");
  a_sync_wait: assert property (@(posedge clock) disable iff (!rst_b)
    apply_go_q && !cfg_async && running && !period_end && !stop_q |=> staged_valid_q && running)
    else $error("sync apply did not wait for period end");
  a_oneshot: assert property (@(posedge clock) disable iff (!rst_b)
    period_end && cfg_oneshot && !staged_valid_q && !apply_go_q && !stop_q |=> !running ##1 !pwm_running)
    else $error("one-shot period did not stop");
  a_repeat: assert property (@(posedge clock) disable iff (!rst_b)
    period_end && !cfg_oneshot && !stop_q |=> running)
    else $error("repeat mode stopped at period end");
  a_latch_slot: assert property (@(posedge clock) disable iff (!rst_b)
    is_latch |=> slot_q == $past(slot_q) + 4'h1)
    else $error("latch did not advance slot");
  a_apply_slot: assert property (@(posedge clock) disable iff (!rst_b)
    is_apply |=> slot_q == 4'h0 && apply_go_q)
    else $error("apply did not reset slot and fire");
  a_wake_time: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(standby) |-> $past(wake_cnt_q, 2) == WAKE_LAST)
    else $error("standby left before wake time");
  a_res_only16: assert property (@(posedge clock) disable iff (!rst_b)
    stby_q == STBY_NORMAL && res_s != RES_16 |=> stby_q == STBY_NORMAL ##1 !standby)
    else $error("standby entered at non-16-bit resolution");
endmodule

// ### verif/ledpwm_host.sv
`timescale 1ns/1ps
module ledpwm_host (
  input wire logic clock,
  output logic serial_clock,
  output logic serial_data_in,
  output logic latch_strobe,
  output logic grey_clock
);
  import ledpwm_pkg::*;

  initial begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
    grey_clock = 1'b0;
  end

  // 5 MHz count clock, well under half the system rate
  initial begin
    #37.3;
    forever #100 grey_clock = ~grey_clock;
  end

  task automatic pulse();
    #3 serial_clock = 1'b1;
    #3 serial_clock = 1'b0;
  endtask

  task automatic link_reset();
    repeat (4) pulse();
  endtask

  // Link clock stands still between frames
  task automatic send_word(input logic [15:0] w, input logic [PCNT_W-1:0] n);
    #1.3;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      pulse();
    end
    // Stale data never left on the line
    serial_data_in = ~w[0];
    latch_strobe = 1'b1;
    for (int i = 0; i < n; i++) begin
      pulse();
    end
    // Strobe must outlast two system clocks to cross reliably
    repeat (3) @(posedge clock);
    #3 latch_strobe = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic apply(input logic [15:0] w);
    send_word(w, CMD_APPLY_PULSES);
  endtask

  // Odd channels take odd_v, even ones even_v
  task automatic load(input logic [15:0] odd_v, input logic [15:0] even_v, input logic speed);
    for (int c = 0; c < CH_N; c++) begin
      if (speed && c == CH_N - 1) begin
        send_word(c[0] ? odd_v : even_v, CMD_APPLY_PULSES);
      end else begin
        send_word(c[0] ? odd_v : even_v, CMD_LATCH_PULSES);
      end
    end
  endtask
endmodule

// ### verif/tb_led_pwm_state_and_load_control.sv
`timescale 1ns/1ps
module tb_led_pwm_state_and_load_control;
  import ledpwm_pkg::*;
  localparam logic [15:0] B_ASYNC = 16'h0001 << SW2_ASYNC;
  localparam logic [15:0] B_ONESHOT = 16'h0001 << SW2_ONESHOT;
  logic clock;
  logic rst_b;
  logic [1:0] resolution_sel;
  logic serial_clock;
  logic serial_data_in;
  logic latch_strobe;
  logic grey_clock;
  logic serial_data_out;
  logic [CH_N-1:0] channel_output;
  logic open_load_detect_en;
  logic short_out_detect_en;
  logic short_threshold_high_sel;
  logic output_delay_en;
  logic standby;
  logic pwm_running;
  int errors;
  int n_compared;

  ledpwm_host host (.clock(clock), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .grey_clock(grey_clock));

  ledpwm_top dut (.clock(clock), .rst_b(rst_b), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .grey_clock(grey_clock), .resolution_sel(resolution_sel),
    .serial_data_out(serial_data_out), .channel_output(channel_output),
    .open_load_detect_en(open_load_detect_en), .short_out_detect_en(short_out_detect_en),
    .short_threshold_high_sel(short_threshold_high_sel), .output_delay_en(output_delay_en),
    .standby(standby), .pwm_running(pwm_running));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      errors++;
    end
    n_compared++;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk("open_en", 16'h0000, open_load_detect_en);
    chk("short_en", 16'h0000, short_out_detect_en);
    chk("thresh", 16'h0000, short_threshold_high_sel);
    chk("delay_en", 16'h0001, output_delay_en);
    chk("standby", 16'h0000, standby);
    chk("running", 16'h0000, pwm_running);
  endtask

  task automatic t_state();
    host.send_word((16'h0001 << SW2_OPEN_EN) | (16'h0001 << SW2_SHORT_EN) | (16'h0001 << SW2_THRESH_HIGH)
      | (16'h0001 << SW2_DELAY_OFF), CMD_SW2_PULSES_A);
    chk("open_en", 16'h0001, open_load_detect_en);
    chk("short_en", 16'h0001, short_out_detect_en);
    chk("thresh", 16'h0001, short_threshold_high_sel);
    chk("delay_en", 16'h0000, output_delay_en);
    host.send_word(16'h0000, CMD_SW2_PULSES_B);
    chk("open_en", 16'h0000, open_load_detect_en);
    chk("delay_en", 16'h0001, output_delay_en);
  endtask

  task automatic t_normal();
    host.load(16'hffff, 16'hffff, 1'b0);
    chk("chan", 16'h0000, channel_output);
    chk("running", 16'h0000, pwm_running);
    host.apply(16'hffff);
    chk("chan", 16'hffff, channel_output);
    chk("running", 16'h0001, pwm_running);
    cyc(11000);
    chk("running", 16'h0001, pwm_running);
    host.send_word(16'h0000, CMD_STOP_PULSES);
    chk("running", 16'h0000, pwm_running);
    chk("chan", 16'h0000, channel_output);
  endtask

  task automatic t_speed_sync();
    host.load(16'hffff, 16'h0000, 1'b1);
    chk("chan", 16'haaaa, channel_output);
    chk("sdo", 16'h0001, serial_data_out);
    host.load(16'h0000, 16'h0000, 1'b0);
    host.apply(16'h0000);
    host.load(16'h0000, 16'hffff, 1'b0);
    host.apply(16'hffff);
    chk("chan", 16'haaaa, channel_output);
    cyc(6000);
    chk("chan", 16'h5555, channel_output);
    host.send_word(16'h0000, CMD_STOP_PULSES);
  endtask

  task automatic t_async_oneshot();
    host.send_word(B_ASYNC, CMD_SW2_PULSES_A);
    host.load(16'hffff, 16'hffff, 1'b0);
    host.apply(16'hffff);
    host.load(16'h0000, 16'h0000, 1'b0);
    chk("chan", 16'hffff, channel_output);
    host.apply(16'h0000);
    chk("chan", 16'h0000, channel_output);
    chk("running", 16'h0001, pwm_running);
    host.send_word(B_ASYNC | B_ONESHOT, CMD_SW2_PULSES_A);
    host.load(16'hffff, 16'hffff, 1'b0);
    host.apply(16'hffff);
    chk("running", 16'h0001, pwm_running);
    cyc(5400);
    chk("running", 16'h0000, pwm_running);
    chk("chan", 16'h0000, channel_output);
    host.apply(16'hffff);
    chk("running", 16'h0001, pwm_running);
    host.send_word(16'h0000, CMD_STOP_PULSES);
  endtask

  task automatic t_divide();
    int rises;
    logic prev;
    rises = 0;
    resolution_sel = RES_12;
    host.send_word((16'h0001 << SW2_DIVIDE) | (16'h0001 << SW2_DELAY_OFF) | (16'h0001 << SW2_SERIAL_DATA_OUT_FALL),
      CMD_SW2_PULSES_B);
    host.load(16'h0100, 16'h0100, 1'b0);
    host.apply(16'h0100);
    prev = channel_output[0];
    // One block per period would give at most one rise in this span
    repeat (2500) begin
      @(negedge clock);
      if (channel_output[0] && !prev) rises++;
      prev = channel_output[0];
    end
    chk("div_rises", 16'h0001, {15'h0000, rises >= 8});
    chk("sdo", 16'h0000, serial_data_out);
    host.send_word(16'h0000, CMD_STOP_PULSES);
    chk("running", 16'h0000, pwm_running);
    resolution_sel = RES_14;
  endtask

  task automatic t_standby();
    host.load(16'h0000, 16'h0000, 1'b0);
    host.apply(16'h0000);
    host.send_word(16'h0001 << SW2_AUTO_STBY, CMD_SW2_PULSES_A);
    cyc(4);
    chk("standby", 16'h0000, standby);
    resolution_sel = RES_16;
    cyc(4);
    chk("standby", 16'h0001, standby);
    host.send_word(16'h00ff, CMD_LATCH_PULSES);
    chk("standby", 16'h0001, standby);
    cyc(700);
    chk("standby", 16'h0001, standby);
    cyc(60);
    chk("standby", 16'h0000, standby);
  endtask

  // About three times the expected run
  initial begin
    #3000000;
    errors++;
    final_report();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    resolution_sel = RES_10;
    host.link_reset();
    cyc(8);
    rst_b = 1'b1;
    // Link-side reset clears only on link clock edges
    host.link_reset();
    cyc(4);
    t_reset();
    t_state();
    t_normal();
    t_speed_sync();
    t_async_oneshot();
    t_divide();
    t_standby();
    final_report();
  end
endmodule
